/* File: mb_index_map.sv */
`timescale 1ns/1ps
`include "media_fe_consts.svh"
module mb_index_map
  import media_fe_pkg::*;
(
  input  wire logic [1:0]  pstruct_in,
  input  wire logic [1:0]  coding_in,
  input  wire logic [5:0]  mb_in,
  input  wire ofs_t        remap_in [`REMAP_ENTRIES],
  output logic      [3:0]  index_out,
  output logic             index_valid_out,
  output ofs_t             offset_out
);
  // direction base shared by both destination kinds; no vectors means a zero forward vector
  function automatic logic [2:0] dir_base(input logic [5:0] mb);
    if (mb[`MB_BWD_BIT] && mb[`MB_FWD_BIT]) dir_base = `IDX_BI;
    else if (mb[`MB_BWD_BIT])               dir_base = `IDX_BWD;
    else                                    dir_base = `IDX_FWD;
  endfunction : dir_base

  // frame motion (field motion for field pictures) takes the base, the other the next slot
  function automatic logic [2:0] kind_index(input logic [5:0] mb, input logic second);
    if (mb[`MB_INTRA_BIT])                    kind_index = `IDX_INTRA;
    else if (mb[`MB_MOT_RNG] == `MOT_DUAL)    kind_index = `IDX_DUAL;
    else                                      kind_index = dir_base(mb) + {2'h0, second};
  endfunction : kind_index

  // one validity test serves both destination kinds, on the low three index bits
  function automatic logic kind_valid(input logic [2:0] k, input logic [1:0] coding);
    case (coding)
      `CODING_I: kind_valid = (k == `IDX_INTRA);
      `CODING_P: kind_valid = (k <= `IDX_P_MAX);
      `CODING_B: kind_valid = (k != `IDX_DUAL);
      default:   kind_valid = 1'b0;
    endcase
  endfunction : kind_valid

  logic [2:0] frame_kind;
  logic [2:0] field_kind;
  logic [3:0] frame_index;
  logic [3:0] field_index;

  // picture structure is stable until flush, so both mappings are built apart and muxed
  always_comb begin
    frame_kind  = kind_index(mb_in, mb_in[`MB_MOT_RNG] == `MOT_FIELD);
    field_kind  = kind_index(mb_in, mb_in[`MB_MOT_RNG] == `MOT_FRAME_16X8);
    frame_index = {mb_in[`MB_DCT_BIT] && !mb_in[`MB_INTRA_BIT] ? 1'b1 : mb_in[`MB_DCT_BIT],
                   frame_kind};
    field_index = {1'b0, field_kind};
    if (pstruct_in == `PS_FRAME) begin
      index_out       = frame_index;
      index_valid_out = kind_valid(frame_kind, coding_in);
    end else begin
      index_out       = field_index;
      index_valid_out = kind_valid(field_kind, coding_in) &&
                        (pstruct_in == `PS_TOP || pstruct_in == `PS_BOT);
    end
    offset_out = remap_in[index_out];
  end
endmodule : mb_index_map

/* File: media_cmd_if.sv */
`timescale 1ns/1ps
interface media_cmd_if;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [31:0] cmd_data;
  modport issuer (output cmd_valid, output cmd_data, input cmd_ready);
  modport device (input cmd_valid, input cmd_data, output cmd_ready);
endinterface : media_cmd_if

/* File: media_cmd_issuer.sv */
`timescale 1ns/1ps
`include "media_fe_consts.svh"
module media_cmd_issuer
  import media_fe_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  media_cmd_if.issuer      link,
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire cmd_kind_t   req_kind_in,
  input  wire logic [31:0] req_arg0_in,
  input  wire logic [31:0] req_arg1_in,
  input  wire ofs_t        req_table_in [`REMAP_ENTRIES],
  input  wire logic        up_avail_in,
  output logic             req_err_out
);
  host_state_t state_reg, state_next;
  logic [31:0] words_reg [`MAX_WORDS];
  logic [31:0] words_next [`MAX_WORDS];
  logic [7:0]  len_reg, len_next;
  logic [7:0]  idx_reg, idx_next;
  logic        last_desc_reg, last_desc_next;
  logic        cb_loaded_reg, cb_loaded_next;
  logic        decode_reg, decode_next;
  logic        err_reg, err_next;

  function automatic logic [31:0] make_hdr(input logic [2:0] opc, input logic [7:0] sub,
                                           input logic [7:0] len);
    make_hdr            = '0;
    make_hdr[`PIPE_RNG] = `PIPE_MEDIA;
    make_hdr[`OPC_RNG]  = opc;
    make_hdr[`SUB_RNG]  = sub;
    make_hdr[`LEN_RNG]  = len;
  endfunction : make_hdr

  assign req_ready_out  = (state_reg == H_IDLE);
  assign link.cmd_valid = (state_reg == H_SEND);
  assign link.cmd_data  = words_reg[idx_reg[2:0]];
  assign req_err_out    = err_reg;

  always_comb begin
    logic refuse;
    refuse         = 1'b0;
    state_next     = state_reg;
    words_next     = words_reg;
    len_next       = len_reg;
    idx_next       = idx_reg;
    last_desc_next = last_desc_reg;
    cb_loaded_next = cb_loaded_reg;
    decode_next    = decode_reg;
    err_next       = 1'b0;
    case (state_reg)
      H_IDLE: begin
        if (req_valid_in) begin
          words_next[1] = req_arg0_in;
          words_next[2] = req_arg1_in;
          case (req_kind_in)
            KIND_FE: begin
              words_next[0] = make_hdr(`OPC_STATE, `SUB_FE, `LEN_FE);
              len_next      = `LEN_FE;
              for (int k = 0; k < `REMAP_ENTRIES; k++) begin
                words_next[`FE_TBL_DW + k / `REMAP_PER_DW]
                  [(k % `REMAP_PER_DW) * `REMAP_LANE +: `REMAP_LANE] = {2'h0, req_table_in[k]};
              end
            end
            KIND_CB: begin
              words_next[0] = make_hdr(`OPC_STATE, `SUB_CB, `LEN_CB);
              len_next      = `LEN_CB;
            end
            KIND_DESC: begin
              refuse        = last_desc_reg;
              words_next[0] = make_hdr(`OPC_STATE, `SUB_DESC, `LEN_DESC);
              len_next      = `LEN_DESC;
            end
            KIND_OBJ: begin
              refuse = !(req_arg0_in[`OBJ_INL_BIT] || req_arg0_in[`OBJ_IND_BIT] ||
                         cb_loaded_reg);
              words_next[0] = make_hdr(`OPC_PRIM, `SUB_OBJ, `LEN_OBJ);
              words_next[1][`OBJ_DEP_RNG] = up_avail_in ? `VC1_UP_DEP : 8'h00;
              len_next      = `LEN_OBJ;
            end
            KIND_WALK: begin
              refuse        = decode_reg;
              words_next[0] = make_hdr(`OPC_PRIM, `SUB_WALK, `LEN_WALK);
              len_next      = `LEN_WALK;
            end
            default: refuse = 1'b1;
          endcase
          err_next = refuse;
          if (refuse) begin
            words_next = words_reg;
            len_next   = len_reg;
          end else begin
            state_next     = H_SEND;
            idx_next       = '0;
            if (req_kind_in == KIND_DESC) last_desc_next = 1'b1;
            if (req_kind_in == KIND_FE) last_desc_next = 1'b0;
            if (req_kind_in == KIND_CB) cb_loaded_next = 1'b1;
            if (req_kind_in == KIND_FE) decode_next = req_arg0_in[`FE_DECODE_BIT];
          end
        end
      end
      H_SEND: begin
        if (link.cmd_ready) begin
          idx_next = idx_reg + 8'h01;
          if (idx_reg == len_reg) begin
            state_next = H_IDLE;
          end
        end
      end
      default: state_next = H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg     <= H_IDLE;
      words_reg     <= '{default: '0};
      len_reg       <= '0;
      idx_reg       <= '0;
      last_desc_reg <= 1'b0;
      cb_loaded_reg <= 1'b0;
      decode_reg    <= 1'b0;
      err_reg       <= 1'b0;
    end else begin
      state_reg     <= state_next;
      words_reg     <= words_next;
      len_reg       <= len_next;
      idx_reg       <= idx_next;
      last_desc_reg <= last_desc_next;
      cb_loaded_reg <= cb_loaded_next;
      decode_reg    <= decode_next;
      err_reg       <= err_next;
    end
  end
endmodule : media_cmd_issuer

/* File: media_fe_consts.svh */
`ifndef MEDIA_FE_CONSTS_SVH
`define MEDIA_FE_CONSTS_SVH
// command header fields
`define PIPE_RNG        28:27
`define OPC_RNG         26:24
`define SUB_RNG         23:16
`define LEN_RNG         7:0
`define PIPE_MEDIA      2'h2
`define OPC_STATE       3'h0
`define OPC_PRIM        3'h1
`define SUB_FE          8'h00
`define SUB_CB          8'h01
`define SUB_DESC        8'h02
`define SUB_OBJ         8'h00
`define SUB_WALK        8'h03
`define LEN_FE          8'h06
`define LEN_CB          8'h01
`define LEN_DESC        8'h01
`define LEN_OBJ         8'h02
`define LEN_WALK        8'h02
// payload dword positions
`define DW1             8'h01
`define FE_BASE_DW      8'h02
`define FE_TBL_DW       3
`define MAX_WORDS       7
// front-end state dword 1
`define FE_DECODE_BIT   0
`define FE_PSTRUCT_RNG  2:1
`define FE_CODING_RNG   4:3
`define FE_SBMASK_RNG   15:8
// primitive dword 1
`define OBJ_OFS_RNG     5:0
`define OBJ_INL_BIT     8
`define OBJ_IND_BIT     9
`define OBJ_DEP_RNG     23:16
// media object dword 2: macroblock parameters
`define MB_INTRA_BIT    0
`define MB_FWD_BIT      1
`define MB_BWD_BIT      2
`define MB_MOT_RNG      4:3
`define MB_DCT_BIT      5
// walker dword 2: thread address
`define WLK_X_RNG       8:0
`define WLK_Y_RNG       24:16
// picture structure, coding type, motion type
`define PS_TOP          2'h1
`define PS_BOT          2'h2
`define PS_FRAME        2'h3
`define CODING_I        2'h1
`define CODING_P        2'h2
`define CODING_B        2'h3
`define MOT_FIELD       2'h1
`define MOT_FRAME_16X8  2'h2
`define MOT_DUAL        2'h3
// macroblock index encoding
`define IDX_INTRA       3'h0
`define IDX_FWD         3'h1
`define IDX_DUAL        3'h3
`define IDX_BWD         3'h4
`define IDX_BI          3'h6
`define IDX_P_MAX       3'h3
`define IDX_DCT_BIT     3
// remap table: 16 six-bit entries, four per dword in byte lanes
`define REMAP_ENTRIES   16
`define REMAP_PER_DW    4
`define REMAP_LANE      8
`define OFS_W           6
// descriptor and thread header
`define DESC_SIZE       32'h00000020
`define HDR2_OFS_RNG    9:4
`define VC1_UP_DEP      8'h01
`endif

/* File: media_fe_pkg.sv */
package media_fe_pkg;
  typedef enum logic [2:0] {KIND_FE, KIND_CB, KIND_DESC, KIND_OBJ, KIND_WALK} cmd_kind_t;
  typedef enum logic [1:0] {D_IDLE, D_PAYLOAD, D_DISPATCH} dev_state_t;
  typedef enum logic {H_IDLE, H_SEND} host_state_t;
  typedef logic [5:0] ofs_t;
endpackage : media_fe_pkg

/* File: media_front_end.sv */
`timescale 1ns/1ps
`include "media_fe_consts.svh"
// Overview of operation
// - decode mode ignores command offset, derives its own
// - index from structure, motion, prediction, DCT, intra, vectors
// - structure 11 uses frame destination mapping
// - structure 01 or 10 uses field mapping
// - index selects remap entry giving final offset
// - pointer is base plus offset times size
// - frame indices 0-7 list eight macroblock kinds
// - frame indices 8-15 add field DCT
// - field indices 0-7 list field kinds
// - frame valid indices depend on picture type
// - field valid indices depend on picture type
// - structure fixed until flush, mappings separate
// - state loaded in-line through state commands
// - descriptors equal-sized, contiguous, chosen by index
// - decode state commands by pipeline, opcode, sub-opcode
// - issuer refuses a descriptor load with no front-end state command since the last
// - issuer gives every object at least one payload
// - walker takes inline only, or no payload once a descriptor is loaded
// - walker scoreboards follow address and state
// - issuer sends walker only in generic mode
// - issuer sets at most one upper dependency
// - offset lands in header dword two, bits 9:4
module media_front_end
  import media_fe_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  media_cmd_if.device      link,
  output logic             thread_valid_out,
  input  wire logic        thread_ready_in,
  output logic      [31:0] thread_hdr2_out,
  output logic      [31:0] desc_ptr_out,
  output logic      [8:0]  sb_x_out,
  output logic      [8:0]  sb_y_out,
  output logic      [7:0]  sb_mask_out,
  output logic      [3:0]  mb_index_out,
  output logic             decode_mode_out,
  output logic             payload_err_out,
  output logic             index_err_out,
  output logic             seq_err_out
);
  dev_state_t  state_reg, state_next;
  logic [31:0] hdr_reg, hdr_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [31:0] dw1_reg, dw1_next;
  logic        decode_reg, decode_next;
  logic [1:0]  pstruct_reg, pstruct_next;
  logic [1:0]  coding_reg, coding_next;
  logic [7:0]  sbmask_reg, sbmask_next;
  logic [31:0] base_reg, base_next;
  ofs_t        remap_reg [`REMAP_ENTRIES];
  ofs_t        remap_next [`REMAP_ENTRIES];
  logic        desc_seen_reg, desc_seen_next;
  logic [31:0] hdr2_reg, hdr2_next;
  logic [31:0] ptr_reg, ptr_next;
  logic [8:0]  sbx_reg, sbx_next;
  logic [8:0]  sby_reg, sby_next;
  logic [7:0]  sbm_reg, sbm_next;
  logic [3:0]  idx_reg, idx_next;
  logic        perr_reg, perr_next;
  logic        ierr_reg, ierr_next;
  logic        serr_reg, serr_next;

  logic        take;
  logic        last_word;
  logic [3:0]  map_index;
  logic        map_valid;
  ofs_t        map_offset;

  // command class test, used for both header and payload handling
  function automatic logic is_cmd(input logic [31:0] h, input logic [2:0] opc,
                                  input logic [7:0] sub);
    is_cmd = (h[`PIPE_RNG] == `PIPE_MEDIA) && (h[`OPC_RNG] == opc) &&
             (h[`SUB_RNG] == sub);
  endfunction : is_cmd

  mb_index_map u_map (
    .pstruct_in      (pstruct_reg),
    .coding_in       (coding_reg),
    .mb_in           (link.cmd_data[5:0]),
    .remap_in        (remap_reg),
    .index_out       (map_index),
    .index_valid_out (map_valid),
    .offset_out      (map_offset)
  );

  // no new word is taken while a thread waits, which back-pressures the streamer
  assign link.cmd_ready   = (state_reg != D_DISPATCH);
  assign take             = link.cmd_valid && link.cmd_ready;
  assign last_word        = (cnt_reg == hdr_reg[`LEN_RNG]);
  assign thread_valid_out = (state_reg == D_DISPATCH);
  assign thread_hdr2_out  = hdr2_reg;
  assign desc_ptr_out     = ptr_reg;
  assign sb_x_out         = sbx_reg;
  assign sb_y_out         = sby_reg;
  assign sb_mask_out      = sbm_reg;
  assign mb_index_out     = idx_reg;
  assign decode_mode_out  = decode_reg;
  assign payload_err_out  = perr_reg;
  assign index_err_out    = ierr_reg;
  assign seq_err_out      = serr_reg;

  always_comb begin
    ofs_t   ofs;
    logic   go;
    ofs            = '0;
    go             = 1'b0;
    state_next     = state_reg;
    hdr_next       = hdr_reg;
    cnt_next       = cnt_reg;
    dw1_next       = dw1_reg;
    decode_next    = decode_reg;
    pstruct_next   = pstruct_reg;
    coding_next    = coding_reg;
    sbmask_next    = sbmask_reg;
    base_next      = base_reg;
    remap_next     = remap_reg;
    desc_seen_next = desc_seen_reg;
    hdr2_next      = hdr2_reg;
    ptr_next       = ptr_reg;
    sbx_next       = sbx_reg;
    sby_next       = sby_reg;
    sbm_next       = sbm_reg;
    idx_next       = idx_reg;
    perr_next      = 1'b0;
    ierr_next      = 1'b0;
    serr_next      = 1'b0;
    case (state_reg)
      D_IDLE: begin
        if (take) begin
          hdr_next = link.cmd_data;
          cnt_next = `DW1;
          if (link.cmd_data[`LEN_RNG] != 8'h00) begin
            state_next = D_PAYLOAD;
          end
          if (is_cmd(link.cmd_data, `OPC_STATE, `SUB_FE)) begin
            desc_seen_next = 1'b0;
          end
          if (is_cmd(link.cmd_data, `OPC_STATE, `SUB_DESC)) begin
            // a second load with no front-end state command between is flagged but still taken
            serr_next      = desc_seen_reg;
            desc_seen_next = 1'b1;
          end
        end
      end
      D_PAYLOAD: begin
        if (take) begin
          cnt_next = cnt_reg + 8'h01;
          if (cnt_reg == `DW1) begin
            dw1_next = link.cmd_data;
          end
          if (is_cmd(hdr_reg, `OPC_STATE, `SUB_FE)) begin
            if (cnt_reg == `DW1) begin
              decode_next  = link.cmd_data[`FE_DECODE_BIT];
              pstruct_next = link.cmd_data[`FE_PSTRUCT_RNG];
              coding_next  = link.cmd_data[`FE_CODING_RNG];
              sbmask_next  = link.cmd_data[`FE_SBMASK_RNG];
            end
            if (cnt_reg == `FE_BASE_DW) begin
              base_next = link.cmd_data;
            end
            for (int k = 0; k < `REMAP_ENTRIES; k++) begin
              if (cnt_reg == 8'(`FE_TBL_DW + k / `REMAP_PER_DW)) begin
                remap_next[k] =
                  link.cmd_data[(k % `REMAP_PER_DW) * `REMAP_LANE +: `OFS_W];
              end
            end
          end
          if (last_word) begin
            state_next = D_IDLE;
            if (is_cmd(hdr_reg, `OPC_PRIM, `SUB_OBJ)) begin
              go = 1'b1;
              if (decode_reg) begin
                ofs       = map_offset;
                idx_next  = map_index;
                ierr_next = !map_valid;
                go        = map_valid;
              end else begin
                ofs = dw1_reg[`OBJ_OFS_RNG];
              end
              sbx_next = '0;
              sby_next = '0;
              sbm_next = dw1_reg[`OBJ_DEP_RNG] & sbmask_reg;
            end
            if (is_cmd(hdr_reg, `OPC_PRIM, `SUB_WALK)) begin
              ofs       = dw1_reg[`OBJ_OFS_RNG];
              perr_next = dw1_reg[`OBJ_IND_BIT] ||
                !(dw1_reg[`OBJ_INL_BIT] || desc_seen_reg);
              go        = !perr_next;
              sbx_next  = link.cmd_data[`WLK_X_RNG];
              sby_next  = link.cmd_data[`WLK_Y_RNG];
              sbm_next  = sbmask_reg;
            end
            if (go) begin
              state_next                = D_DISPATCH;
              hdr2_next                 = '0;
              hdr2_next[`HDR2_OFS_RNG]  = ofs;
              ptr_next = base_reg + 32'(ofs) * `DESC_SIZE;
            end
          end
        end
      end
      D_DISPATCH: begin
        if (thread_ready_in) begin
          state_next = D_IDLE;
        end
      end
      default: state_next = D_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg     <= D_IDLE;
      hdr_reg       <= '0;
      cnt_reg       <= '0;
      dw1_reg       <= '0;
      decode_reg    <= 1'b0;
      pstruct_reg   <= `PS_FRAME;
      coding_reg    <= `CODING_I;
      sbmask_reg    <= '0;
      base_reg      <= '0;
      remap_reg     <= '{default: '0};
      desc_seen_reg <= 1'b0;
      hdr2_reg      <= '0;
      ptr_reg       <= '0;
      sbx_reg       <= '0;
      sby_reg       <= '0;
      sbm_reg       <= '0;
      idx_reg       <= '0;
      perr_reg      <= 1'b0;
      ierr_reg      <= 1'b0;
      serr_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      hdr_reg       <= hdr_next;
      cnt_reg       <= cnt_next;
      dw1_reg       <= dw1_next;
      decode_reg    <= decode_next;
      pstruct_reg   <= pstruct_next;
      coding_reg    <= coding_next;
      sbmask_reg    <= sbmask_next;
      base_reg      <= base_next;
      remap_reg     <= remap_next;
      desc_seen_reg <= desc_seen_next;
      hdr2_reg      <= hdr2_next;
      ptr_reg       <= ptr_next;
      sbx_reg       <= sbx_next;
      sby_reg       <= sby_next;
      sbm_reg       <= sbm_next;
      idx_reg       <= idx_next;
      perr_reg      <= perr_next;
      ierr_reg      <= ierr_next;
      serr_reg      <= serr_next;
    end
  end
endmodule : media_front_end

/* File: media_front_end_asserts.sv */
`timescale 1ns/1ps
module media_front_end_asserts (
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [31:0] cmd_data,
  input wire logic        thread_valid_out,
  input wire logic        thread_ready_in,
  input wire logic [31:0] thread_hdr2_out,
  input wire logic [31:0] desc_ptr_out,
  input wire logic        index_err_out,
  input wire logic        payload_err_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_valid_holds: assert property (cmd_valid && !cmd_ready |=> cmd_valid)
    else $error("command word dropped before it was taken");
  a_data_holds: assert property (cmd_valid && !cmd_ready |=> $stable(cmd_data))
    else $error("command word changed before it was taken");
  a_ready_blocked: assert property (thread_valid_out |-> !cmd_ready)
    else $error("link accepts words while a thread is pending");
  a_hdr_format: assert property (thread_valid_out |->
    thread_hdr2_out[31:10] == 22'h0 && thread_hdr2_out[3:0] == 4'h0)
    else $error("header dword has bits outside the offset field");
  a_thread_holds: assert property (thread_valid_out && !thread_ready_in |=>
    thread_valid_out && $stable(desc_ptr_out) && $stable(thread_hdr2_out))
    else $error("pending thread changed before acceptance");
  a_accept_frees: assert property (thread_valid_out && thread_ready_in |=>
    !thread_valid_out && cmd_ready)
    else $error("link not reopened after thread acceptance");
  a_bad_index_drop: assert property (index_err_out |->
    !thread_valid_out ##1 !index_err_out)
    else $error("invalid index dispatched a thread or error not a pulse");
  a_payload_drop: assert property (payload_err_out |->
    !thread_valid_out ##1 !payload_err_out)
    else $error("walker payload fault dispatched a thread");
  a_reset_idle: assert property (@(posedge mclk_in) disable iff (1'b0)
    rst_in |=> !cmd_valid && !thread_valid_out)
    else $error("link or thread active after reset");
endmodule : media_front_end_asserts

/* File: media_kernel_descriptor_select_tb.sv */
`timescale 1ns/1ps
module media_kernel_descriptor_select_tb import media_fe_pkg::*;;
  typedef struct {logic [1:0] ps; logic [1:0] cd; logic [5:0] mb;
    logic [3:0] idx; logic ok;} row_t;
  localparam logic [31:0] BASE = 32'h00001000;
  logic        mclk_in, rst_in, req_valid_in, req_ready_out, req_err_out, up_avail_in, seq_err2;
  logic        thread_valid_out, thread_ready_in, decode_mode_out, payload_err_out, index_err_out;
  logic [31:0] req_arg0_in, req_arg1_in, thread_hdr2_out, desc_ptr_out;
  logic [8:0]  sb_x_out, sb_y_out;
  logic [7:0]  sb_mask_out;
  logic [3:0]  mb_index_out;
  cmd_kind_t   req_kind_in;
  ofs_t        req_table_in [16];
  logic [31:0] wq [$];
  int          mismatches, tests_run, n_ie, n_pe, n_re, n_se;
  row_t        rows [11];
  media_cmd_if lnk ();
  media_cmd_if lnk2 ();
  media_cmd_issuer u_media_cmd_issuer (.mclk_in(mclk_in), .rst_in(rst_in), .link(lnk),
    .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_kind_in(req_kind_in),
    .req_arg0_in(req_arg0_in), .req_arg1_in(req_arg1_in), .req_table_in(req_table_in),
    .up_avail_in(up_avail_in), .req_err_out(req_err_out));
  media_front_end u_media_front_end (.mclk_in(mclk_in), .rst_in(rst_in), .link(lnk),
    .thread_valid_out(thread_valid_out), .thread_ready_in(thread_ready_in),
    .thread_hdr2_out(thread_hdr2_out), .desc_ptr_out(desc_ptr_out), .sb_x_out(sb_x_out),
    .sb_y_out(sb_y_out), .sb_mask_out(sb_mask_out), .mb_index_out(mb_index_out),
    .decode_mode_out(decode_mode_out), .payload_err_out(payload_err_out),
    .index_err_out(index_err_out), .seq_err_out());
  // second end driven raw so the issuer's own guards cannot hide a sequencing fault
  media_front_end u_media_front_end_2 (.mclk_in(mclk_in), .rst_in(rst_in), .link(lnk2),
    .thread_valid_out(), .thread_ready_in(1'b1), .thread_hdr2_out(), .desc_ptr_out(),
    .sb_x_out(), .sb_y_out(), .sb_mask_out(), .mb_index_out(), .decode_mode_out(),
    .payload_err_out(), .index_err_out(), .seq_err_out(seq_err2));
  media_front_end_asserts u_media_front_end_asserts (.mclk_in(mclk_in), .rst_in(rst_in),
    .cmd_valid(lnk.cmd_valid), .cmd_ready(lnk.cmd_ready), .cmd_data(lnk.cmd_data),
    .thread_valid_out(thread_valid_out), .thread_ready_in(thread_ready_in),
    .thread_hdr2_out(thread_hdr2_out), .desc_ptr_out(desc_ptr_out),
    .index_err_out(index_err_out), .payload_err_out(payload_err_out));
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (index_err_out === 1'b1) n_ie++;
    if (payload_err_out === 1'b1) n_pe++;
    if (req_err_out === 1'b1) n_re++;
    if (seq_err2 === 1'b1) n_se++;
    if (lnk.cmd_valid === 1'b1 && lnk.cmd_ready === 1'b1) wq.push_back(lnk.cmd_data);
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic req(input cmd_kind_t k, input logic [31:0] a0, input logic [31:0] a1);
    int n;
    n = 0;
    do begin
      @(posedge mclk_in) #1;
      n++;
    end while (req_ready_out !== 1'b1 && n < 60);
    if (n >= 60) begin mismatches++; conclude(); end
    req_kind_in = k; req_arg0_in = a0; req_arg1_in = a1; req_valid_in = 1'b1;
    @(posedge mclk_in) #1 req_valid_in = 1'b0;
  endtask : req
  task automatic fe(input logic dec, input logic [1:0] ps, input logic [1:0] cd);
    req(KIND_FE, {16'h0, 8'hff, 3'h0, cd, ps, dec}, BASE);
  endtask : fe
  task automatic ev(input string what, ref int cnt, input int want);
    int n;
    for (n = 0; n < 30 && cnt != want; n++) @(posedge mclk_in) #1;
    chk(what, want, cnt);
  endtask : ev
  task automatic take(input logic [5:0] ofs);
    int n;
    for (n = 0; n < 30 && thread_valid_out !== 1'b1; n++) @(posedge mclk_in) #1;
    if (n >= 30) begin mismatches++; conclude(); end
    repeat (2) @(posedge mclk_in) #1;
    chk("cmd_ready", 0, lnk.cmd_ready);
    chk("thread_hdr2", {22'h0, ofs, 4'h0}, thread_hdr2_out);
    chk("desc_ptr", BASE + {26'h0, ofs} * 32'h20, desc_ptr_out);
    thread_ready_in = 1'b1;
    @(posedge mclk_in) #1 thread_ready_in = 1'b0;
  endtask : take
  task automatic raw(input logic [31:0] w);
    int n;
    lnk2.cmd_valid = 1'b1; lnk2.cmd_data = w;
    for (n = 0; n < 30 && lnk2.cmd_ready !== 1'b1; n++) @(posedge mclk_in) #1;
    if (lnk2.cmd_ready !== 1'b1) mismatches++;
    @(posedge mclk_in) #1;
  endtask : raw
  initial begin
    // {structure, coding, mb params, index, valid}
    rows = '{'{2'h3, 2'h3, 6'h12, 4'h1, 1'b1}, '{2'h3, 2'h3, 6'h0c, 4'h5, 1'b1},
             '{2'h3, 2'h3, 6'h2e, 4'hf, 1'b1}, '{2'h3, 2'h2, 6'h1a, 4'h3, 1'b1},
             '{2'h3, 2'h1, 6'h21, 4'h8, 1'b1}, '{2'h1, 2'h3, 6'h16, 4'h7, 1'b1},
             '{2'h2, 2'h2, 6'h0a, 4'h1, 1'b1}, '{2'h1, 2'h3, 6'h14, 4'h5, 1'b1},
             '{2'h3, 2'h1, 6'h12, 4'h0, 1'b0}, '{2'h3, 2'h3, 6'h1a, 4'h0, 1'b0},
             '{2'h2, 2'h1, 6'h0a, 4'h0, 1'b0}};
    for (int k = 0; k < 16; k++) req_table_in[k] = 6'(k + 16);
    rst_in = 1'b1; req_valid_in = 1'b0; thread_ready_in = 1'b0; up_avail_in = 1'b1;
    req_kind_in = KIND_FE; req_arg0_in = 32'h0; req_arg1_in = 32'h0;
    lnk2.cmd_valid = 1'b0; lnk2.cmd_data = 32'h0;
    repeat (5) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    chk("reset cmd_ready", 1, lnk.cmd_ready);
    chk("reset req_ready", 1, req_ready_out);
    chk("reset desc_ptr", 0, desc_ptr_out);
    chk("reset decode_mode", 0, decode_mode_out);
    req(KIND_OBJ, 32'h0, 32'h0);
    ev("no payload refused", n_re, 1);
    for (int j = 0; j < 3; j++) begin
      req(j == 0 ? KIND_FE : j == 1 ? KIND_CB : KIND_DESC, 32'h0, BASE);
      wq.delete();
      for (int n = 0; n < 30 && wq.size() == 0; n++) @(posedge mclk_in) #1;
      chk("header", j == 0 ? 32'h10000006 : 32'h10010001 + (j - 1) * 32'h10000,
          wq[0]);
    end
    req(KIND_DESC, 32'h0, 32'h0);
    ev("repeat descriptor load refused", n_re, 2);
    for (int i = 0; i < 11; i++) begin
      fe(1'b1, rows[i].ps, rows[i].cd);
      req(KIND_OBJ, 32'h0000013f, {26'h0, rows[i].mb});
      if (rows[i].ok) begin
        take(6'(rows[i].idx + 16));
        chk("mb_index", rows[i].idx, mb_index_out);
      end else ev("index_err", n_ie, n_ie + 1);
    end
    chk("decode_mode", 1, decode_mode_out);
    fe(1'b0, 2'h3, 2'h3);
    req(KIND_OBJ, 32'h00000025, 32'h12);
    take(6'h25);
    chk("sb_mask", 8'h01, sb_mask_out);
    req(KIND_WALK, 32'h00000100, 32'h00a5013c);
    take(6'h00);
    chk("sb_x", 9'h13c, sb_x_out);
    chk("sb_y", 9'h0a5, sb_y_out);
    req(KIND_WALK, 32'h00000200, 32'h0);
    ev("walker indirect", n_pe, 1);
    fe(1'b1, 2'h3, 2'h1);
    req(KIND_WALK, 32'h00000100, 32'h0);
    ev("walker in decode mode", n_re, 3);
    raw(32'h10020001); raw(32'h0); raw(32'h10020001); raw(32'h0);
    lnk2.cmd_valid = 1'b0;
    ev("seq_err", n_se, 1);
    conclude();
  end
endmodule : media_kernel_descriptor_select_tb
